/* rtl/pcw_pkg.sv */
package pcw_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0]  PCW_ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  PCW_ADDR_STAT   = 4'h4;
  localparam logic [3:0]  PCW_ADDR_SETPT  = 4'h8;
  localparam logic [3:0]  PCW_ADDR_TAKEN  = 4'hc;
  localparam logic [15:0] PCW_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] PCW_CTRL_USED   = 16'hd70f;
  // ****************************************
  // Control word fields
  // ****************************************
  localparam int PCW_C_BLK_LSB  = 0;
  localparam int PCW_C_BLK_MSB  = 3;
  localparam int PCW_C_ABS      = 8;
  localparam int PCW_C_DIR_LSB  = 9;
  localparam int PCW_C_DIR_MSB  = 10;
  localparam int PCW_C_CONT     = 12;
  localparam int PCW_C_SETUP    = 14;
  localparam int PCW_C_DIRECT   = 15;
  // ****************************************
  // Status word fields
  // ****************************************
  localparam int PCW_S_BLK_MSB  = 5;
  localparam int PCW_S_CAM_NEG  = 8;
  localparam int PCW_S_CAM_POS  = 9;
  localparam int PCW_S_JOG      = 10;
  localparam int PCW_S_REFAPP   = 11;
  localparam int PCW_S_FLYREF   = 12;
  localparam int PCW_S_BLKACT   = 13;
  localparam int PCW_S_SETUP    = 14;
  localparam int PCW_S_DIRECT   = 15;
  localparam int PCW_GEN_ACCEPT = 6;
  typedef enum logic [2:0] {
    PCW_ROT_SHORT = 3'b001,
    PCW_ROT_POS   = 3'b010,
    PCW_ROT_NEG   = 3'b100
  } pcw_rot_e;
endpackage

/* rtl/pcw_top.sv */
// Functional notes
// - Control bits 0..3 carry the number of the block to run, used to choose it.
// - Control bit 8 low means the setpoint is a distance from the start position.
// - Control bit 8 high means the setpoint is absolute, from machine zero.
// - On a rotary axis, direction field 01 moves positive and 10 moves negative.
// - On a rotary axis, direction field 00 or 11 takes the shorter way round.
// - Control bit 12 high takes every setpoint change at once.
// - Control bit 12 low takes a setpoint only on a rising edge of general bit 6.
// - Control bit 14 high selects set-up mode, low selects positioning mode.
// - Control bit 15 high takes the setpoint directly from the controller.
// - Status bits 0..5 carry the active block number, LSB at bit 0.
// - Status bits 8 and 9 show the negative and positive stop cam.
// - Status bit 10 is high while jogging.
// - Status bit 11 is high while a reference point approach runs.
// - Status bit 12 is high while on-the-fly referencing is armed.
// - Status bit 13 is high while a stored block supplies the setpoint.
// - Status bit 14 shows set-up mode and bit 15 direct setpoint input.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module pcw_top
  import pcw_pkg::*;
#(
  parameter int SP_W = 32
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic [3:0]      reg_addr,
  input  wire logic [15:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [15:0]     reg_rdata,
  input  wire logic [15:0]     general_ctrl_word,
  input  wire logic [SP_W-1:0] setpoint_in,
  input  wire logic [5:0]      active_block,
  input  wire logic            stop_cam_neg,
  input  wire logic            stop_cam_pos,
  input  wire logic            jog_active,
  input  wire logic            ref_approach_active,
  input  wire logic            fly_ref_active,
  input  wire logic            block_active,
  input  wire logic            rotary_axis,
  output logic      [3:0]      block_select,
  output logic                 abs_mode,
  output logic                 rel_mode,
  output logic                 rot_dir_pos,
  output logic                 rot_dir_neg,
  output logic                 rot_shortest,
  output logic                 setup_mode,
  output logic                 direct_setpoint_input,
  output logic      [SP_W-1:0] setpoint_out,
  output logic                 setpoint_take,
  output logic      [15:0]     positioning_status_word_one
);

  // ****************************************
  // Control word register
  // ****************************************
  logic [15:0] positioning_control_word_one_r;
  logic        accept_r;
  logic        accept_d_r;
  logic        accept_s1_r;
  logic [15:0] take_count_r;
  logic        take_nxt;
  pcw_rot_e    rot_nxt;

  // Reserved bits masked on write, so they read back zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      positioning_control_word_one_r <= PCW_CTRL_RESET;
    end else if (reg_wr && reg_addr == PCW_ADDR_CTRL) begin
      positioning_control_word_one_r <= reg_wdata & PCW_CTRL_USED;
    end
  end

  // ****************************************
  // Acceptance strobe
  // ****************************************
  // General control word is from the controller domain: two stages first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accept_s1_r <= 1'b0;
      accept_r    <= 1'b0;
    end else begin
      accept_s1_r <= general_ctrl_word[PCW_GEN_ACCEPT];
      accept_r    <= accept_s1_r;
    end
  end

  // Delay stage for rising-edge detection, idle low like the pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accept_d_r <= 1'b0;
    end else begin
      accept_d_r <= accept_r;
    end
  end

  // A steady input is taken once: compare against the held value
  always_comb begin
    if (positioning_control_word_one_r[PCW_C_CONT]) begin
      take_nxt = (setpoint_in != setpoint_out);
    end else begin
      take_nxt = accept_r && !accept_d_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      setpoint_out  <= '0;
      setpoint_take <= 1'b0;
    end else begin
      setpoint_take <= take_nxt;
      if (take_nxt) begin
        setpoint_out <= setpoint_in;
      end
    end
  end

  // Take counter wraps at 16 bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      take_count_r <= 16'h0000;
    end else if (take_nxt) begin
      take_count_r <= take_count_r + 16'h0001;
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  always_comb begin
    case (positioning_control_word_one_r[PCW_C_DIR_MSB:PCW_C_DIR_LSB])
      2'b01:   rot_nxt = PCW_ROT_POS;
      2'b10:   rot_nxt = PCW_ROT_NEG;
      default: rot_nxt = PCW_ROT_SHORT;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      block_select <= 4'h0;
    end else begin
      block_select <= positioning_control_word_one_r[PCW_C_BLK_MSB:PCW_C_BLK_LSB];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      abs_mode <= 1'b0;
    end else begin
      abs_mode <= positioning_control_word_one_r[PCW_C_ABS];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rel_mode <= 1'b1;
    end else begin
      rel_mode <= !positioning_control_word_one_r[PCW_C_ABS];
    end
  end

  // Direction outputs stay low on a linear axis
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rot_dir_pos <= 1'b0;
    end else begin
      rot_dir_pos <= rotary_axis && rot_nxt == PCW_ROT_POS;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rot_dir_neg <= 1'b0;
    end else begin
      rot_dir_neg <= rotary_axis && rot_nxt == PCW_ROT_NEG;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rot_shortest <= 1'b0;
    end else begin
      rot_shortest <= rotary_axis && rot_nxt == PCW_ROT_SHORT;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      setup_mode <= 1'b0;
    end else begin
      setup_mode <= positioning_control_word_one_r[PCW_C_SETUP];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      direct_setpoint_input <= 1'b0;
    end else begin
      direct_setpoint_input <= positioning_control_word_one_r[PCW_C_DIRECT];
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  // Status follows its inputs one cycle later
  logic [15:0] stat_nxt;

  always_comb begin
    stat_nxt                               = 16'h0000;
    stat_nxt[PCW_S_BLK_MSB:0]              = active_block;
    stat_nxt[PCW_S_CAM_NEG]                = stop_cam_neg;
    stat_nxt[PCW_S_CAM_POS]                = stop_cam_pos;
    stat_nxt[PCW_S_JOG]                    = jog_active;
    stat_nxt[PCW_S_REFAPP]                 = ref_approach_active;
    stat_nxt[PCW_S_FLYREF]                 = fly_ref_active;
    stat_nxt[PCW_S_BLKACT]                 = block_active;
    stat_nxt[PCW_S_SETUP]                  = setup_mode;
    stat_nxt[PCW_S_DIRECT]                 = direct_setpoint_input;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      positioning_status_word_one <= 16'h0000;
    end else begin
      positioning_status_word_one <= stat_nxt;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  // Read data stands one cycle, zero otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        PCW_ADDR_CTRL:  reg_rdata <= positioning_control_word_one_r;
        PCW_ADDR_STAT:  reg_rdata <= positioning_status_word_one;
        PCW_ADDR_SETPT: reg_rdata <= setpoint_out[15:0];
        PCW_ADDR_TAKEN: reg_rdata <= take_count_r;
        default:        reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_block_select: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == PCW_ADDR_CTRL |-> ##2 block_select == $past(reg_wdata[3:0], 2))
    else $error("block select mismatch");
  a_abs_rel_excl: assert property (@(posedge clk) disable iff (!reset_n)
    abs_mode != rel_mode)
    else $error("abs and rel both or neither");
  a_abs_follows: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 abs_mode == $past(positioning_control_word_one_r[PCW_C_ABS]))
    else $error("abs mode not from bit 8");
  a_rot_pos_dir: assert property (@(posedge clk) disable iff (!reset_n)
    rotary_axis && positioning_control_word_one_r[10:9] == 2'b01 |=> rot_dir_pos && !rot_dir_neg)
    else $error("rotary positive not selected");
  a_rot_shortest: assert property (@(posedge clk) disable iff (!reset_n)
    rotary_axis && (positioning_control_word_one_r[10] == positioning_control_word_one_r[9])
    |=> rot_shortest && !rot_dir_pos && !rot_dir_neg)
    else $error("shortest way not selected");
  a_cont_take: assert property (@(posedge clk) disable iff (!reset_n)
    positioning_control_word_one_r[PCW_C_CONT] && setpoint_in != setpoint_out
    |=> setpoint_take && setpoint_out == $past(setpoint_in))
    else $error("continuous take missed");
  a_strobe_only: assert property (@(posedge clk) disable iff (!reset_n)
    !positioning_control_word_one_r[PCW_C_CONT] && !(accept_r && !accept_d_r)
    |=> !setpoint_take && $stable(setpoint_out))
    else $error("setpoint taken without strobe edge");
  a_setup_stat: assert property (@(posedge clk) disable iff (!reset_n)
    ##2 positioning_status_word_one[PCW_S_SETUP] == $past(positioning_control_word_one_r[PCW_C_SETUP], 2))
    else $error("set-up status lags wrongly");
  a_direct_stat: assert property (@(posedge clk) disable iff (!reset_n)
    ##2 positioning_status_word_one[PCW_S_DIRECT] == $past(positioning_control_word_one_r[PCW_C_DIRECT], 2))
    else $error("direct input status wrong");
  a_stat_block: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 positioning_status_word_one[5:0] == $past(active_block))
    else $error("block number status wrong");
  a_stat_flags: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 positioning_status_word_one[13:8] == $past({block_active, fly_ref_active, ref_approach_active,
                                                    jog_active, stop_cam_pos, stop_cam_neg}))
    else $error("status flags wrong");
  a_stat_resv: assert property (@(posedge clk) disable iff (!reset_n)
    positioning_status_word_one[7:6] == 2'b00 && positioning_control_word_one_r[13] == 1'b0)
    else $error("reserved bits not zero");
  // Mode outputs one cycle behind the control register; mode status bits, setpoint take, take count, reserved bits
  a_rel_follows: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 rel_mode == !$past(positioning_control_word_one_r[PCW_C_ABS]))
    else $error("rel mode not from bit 8");
  a_setup_follows: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 setup_mode == $past(positioning_control_word_one_r[PCW_C_SETUP]))
    else $error("set-up mode not from bit 14");
  a_direct_follows: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 direct_setpoint_input == $past(positioning_control_word_one_r[PCW_C_DIRECT]))
    else $error("direct input not from bit 15");
  a_stat_modes: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 positioning_status_word_one[PCW_S_DIRECT:PCW_S_SETUP] == $past({direct_setpoint_input, setup_mode}))
    else $error("mode status bits wrong");
  a_rot_neg_dir: assert property (@(posedge clk) disable iff (!reset_n)
    rotary_axis && positioning_control_word_one_r[PCW_C_DIR_MSB:PCW_C_DIR_LSB] == 2'b10
    |=> rot_dir_neg && !rot_dir_pos)
    else $error("rotary negative not selected");
  a_rot_gated: assert property (@(posedge clk) disable iff (!reset_n)
    !rotary_axis |=> !rot_dir_pos && !rot_dir_neg && !rot_shortest)
    else $error("rotary decode on linear axis");
  a_strobe_take: assert property (@(posedge clk) disable iff (!reset_n)
    !positioning_control_word_one_r[PCW_C_CONT] && accept_r && !accept_d_r
    |=> setpoint_take && setpoint_out == $past(setpoint_in))
    else $error("strobe edge take missed");
  a_cont_hold: assert property (@(posedge clk) disable iff (!reset_n)
    positioning_control_word_one_r[PCW_C_CONT] && setpoint_in == setpoint_out
    |=> !setpoint_take && $stable(setpoint_out))
    else $error("continuous take without change");
  a_take_count: assert property (@(posedge clk) disable iff (!reset_n)
    setpoint_take |-> take_count_r == $past(take_count_r) + 16'h0001)
    else $error("take count not stepped");
  a_ctrl_resv: assert property (@(posedge clk) disable iff (!reset_n)
    (positioning_control_word_one_r & ~PCW_CTRL_USED) == 16'h0000)
    else $error("reserved control bits stored");
  // Register reads
  a_ctrl_readback: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == PCW_ADDR_CTRL |=> reg_rdata == $past(positioning_control_word_one_r))
    else $error("control read back wrong");
  a_stat_readback: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == PCW_ADDR_STAT |=> reg_rdata == $past(positioning_status_word_one))
    else $error("status read back wrong");

  // ****************************************
  // Cover properties
  // ****************************************
  c_strobe_take: cover property (@(posedge clk) disable iff (!reset_n)
    !positioning_control_word_one_r[PCW_C_CONT] ##1 setpoint_take);
  c_cont_take: cover property (@(posedge clk) disable iff (!reset_n)
    positioning_control_word_one_r[PCW_C_CONT] ##1 setpoint_take);
  c_rot_neg: cover property (@(posedge clk) disable iff (!reset_n) rot_dir_neg);
  c_rot_short: cover property (@(posedge clk) disable iff (!reset_n) rot_shortest);
  c_stat_read: cover property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == PCW_ADDR_STAT);

endmodule

/* tb/pcw_partner.sv */
`timescale 1ns/1ns
// ****************************************
// Controller side: setpoint and accept strobe
// ****************************************
module pcw_partner (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        sp_req,
  input  wire logic [31:0] sp_val,
  input  wire logic        strobe_req,
  output logic      [15:0] general_ctrl_word,
  output logic      [31:0] setpoint_in
);
  logic [2:0] hold_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      setpoint_in <= 32'h0;
    end else if (sp_req) begin
      setpoint_in <= sp_val;
    end
  end
  // Strobe high four cycles, then low so a fresh rise can follow
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_r <= 3'h0;
    end else if (strobe_req) begin
      hold_r <= 3'h6;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end
  end
  // Unused bits 0..5 carry changing noise, bits 7..15 stay zero
  assign general_ctrl_word = {9'h0, hold_r > 3'h2, hold_r, hold_r};
endmodule

/* tb/pcw_top_bench.sv */
`timescale 1ns/1ns
module pcw_top_bench;
  import pcw_pkg::*;
  logic        clk        = 1'b0;
  logic        reset_n    = 1'b0;
  logic [3:0]  reg_addr   = 4'h0;
  logic [15:0] reg_wdata  = 16'h0;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic        rd_p       = 1'b0;
  logic        sp_req     = 1'b0;
  logic        strobe_req = 1'b0;
  logic [31:0] sp_val     = 32'h0;
  logic [5:0]  act_blk    = 6'h0;
  logic [6:0]  flags      = 7'h0;
  logic [7:0]  lf         = 8'h2d;
  logic [15:0] reg_rdata, gen_word, status_word, cw;
  logic [31:0] sp_in, sp_out;
  logic [3:0]  blk_sel;
  logic [6:0]  outs;
  logic [2:0]  rot_exp;
  logic        take;
  logic [15:0] exp_q[$];
  int          bad_count   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          takes       = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  pcw_partner ctrl_side (.clk(clk), .reset_n(reset_n), .sp_req(sp_req), .sp_val(sp_val),
    .strobe_req(strobe_req), .general_ctrl_word(gen_word), .setpoint_in(sp_in));

  pcw_top #(.SP_W(32)) dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .general_ctrl_word(gen_word),
    .setpoint_in(sp_in), .active_block(act_blk), .stop_cam_neg(flags[0]), .stop_cam_pos(flags[1]),
    .jog_active(flags[2]), .ref_approach_active(flags[3]), .fly_ref_active(flags[4]),
    .block_active(flags[5]), .rotary_axis(flags[6]), .block_select(blk_sel), .abs_mode(outs[0]),
    .rel_mode(outs[1]), .rot_dir_pos(outs[2]), .rot_dir_neg(outs[3]), .rot_shortest(outs[4]),
    .setup_mode(outs[5]), .direct_setpoint_input(outs[6]), .setpoint_out(sp_out),
    .setpoint_take(take), .positioning_status_word_one(status_word));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    comparisons++;
    if (seen !== expd) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic sp_step(input logic [31:0] v, input logic strobe, input logic [15:0] n, input logic [31:0] e);
    @(posedge clk);
    sp_val <= v;
    sp_req <= 1'b1;
    @(posedge clk);
    sp_req     <= 1'b0;
    strobe_req <= strobe;
    @(posedge clk);
    strobe_req <= 1'b0;
    wait_n(8);
    check(sp_out, e);
    check(takes, n);
    rd(PCW_ADDR_SETPT, e[15:0]);
    rd(PCW_ADDR_TAKEN, n);
  endtask

  // ****************************************
  // Read data monitor and timeout
  // ****************************************
  always @(posedge clk) begin
    if (rd_p) begin
      check(reg_rdata, exp_q.pop_front());
    end
    if (take) begin
      takes++;
    end
    rd_p <= reg_rd;
    cycles++;
    if (cycles > 3000) begin
      bad_count++;
      finish_test;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(PCW_ADDR_CTRL, PCW_CTRL_RESET);
    rd(4'h2, 16'h0);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr_next(lf);
      cw = (({lf, lf} & 16'he9ff) | {5'h0, i[1:0], 9'h0});
      @(posedge clk);
      flags   <= {i[2], lf[5:0]};
      act_blk <= lf[7:2];
      wr(PCW_ADDR_CTRL, cw);
      wr(PCW_ADDR_STAT, 16'hffff);
      wait_n(4);
      rot_exp = i[1:0] == 2'b01 ? 3'b001 : (i[1:0] == 2'b10 ? 3'b010 : 3'b100);
      check(blk_sel, cw[3:0]);
      check(outs[1:0], {~cw[8], cw[8]});
      check(outs[4:2], i[2] ? rot_exp : 3'b000);
      check(outs[6:5], cw[15:14]);
      check(status_word, {cw[15:14], flags[5:0], 2'b00, act_blk});
      rd(PCW_ADDR_CTRL, cw & PCW_CTRL_USED);
      rd(PCW_ADDR_STAT, {cw[15:14], flags[5:0], 2'b00, act_blk});
    end
    lf = lfsr_next(lf);
    sp_step({4{lf}}, 1'b0, 16'h0, 32'h0);
    sp_step({4{lf}}, 1'b1, 16'h1, {4{lf}});
    wr(PCW_ADDR_CTRL, 16'h1000);
    sp_step({lf, 24'h5a3c17}, 1'b0, 16'h2, {lf, 24'h5a3c17});
    sp_step({lf, 24'h5a3c17}, 1'b1, 16'h2, {lf, 24'h5a3c17});
    finish_test;
  end
endmodule
